// ### shared/pot_pkg.sv
`default_nettype none
package pot_pkg;

   // Reference bus: 16-bit data, two-clock accesses without wait states
   localparam int         BUS_WIDTH      = 16;
   localparam int         BUS_CLOCKS     = 2;
   localparam logic [3:0] BUS_LAST       = 4'(BUS_CLOCKS - 1);
   localparam logic [1:0] MIN_WORDS      = 2'h2;
   localparam logic [1:0] MAX_WORDS      = 2'h3;
   localparam logic [7:0] BRANCH_MIN_CYC = 8'(3 * BUS_CLOCKS);
   localparam logic [3:0] LONG_EXTRA     = 4'h2;
   localparam logic [7:0] LONG_EXTRA_CYC = 8'h02;

   typedef enum logic [1:0] {
      KIND_FETCH = 2'b00,
      KIND_READ  = 2'b01,
      KIND_WRITE = 2'b10
   } bus_kind_e;

   typedef enum logic [2:0] {
      EA_DREG    = 3'b000,
      EA_AREG    = 3'b001,
      EA_IND     = 3'b010,
      EA_POSTINC = 3'b011,
      EA_PREDEC  = 3'b100,
      EA_DISP    = 3'b101,
      EA_ABSW    = 3'b110,
      EA_IMMW    = 3'b111
   } ea_mode_e;

   function automatic logic [3:0] min4(input logic [3:0] a, input logic [3:0] b);
      return (a < b) ? a : b;
   endfunction

endpackage
`default_nettype wire

// ### hdl/operand_fetch_address_timing.sv
`default_nettype none
module operand_fetch_address_timing
   import pot_pkg::*;
(
   input  wire logic [2:0] mode_i,
   input  wire logic       long_i,
   output logic      [3:0] head_o,
   output logic      [3:0] tail_o,
   output logic      [7:0] cyc_o,
   output logic      [1:0] rd_o
);

   always_comb begin
      unique case (ea_mode_e'(mode_i))
         EA_DREG, EA_AREG: begin
            head_o = 4'h0; tail_o = 4'h0; cyc_o = 8'h00; rd_o = 2'h0; // RULE20
         end
         EA_IND, EA_POSTINC: begin
            head_o = 4'h1; tail_o = 4'h1; cyc_o = 8'h03; rd_o = 2'h1; // RULE20
         end
         EA_PREDEC: begin
            head_o = 4'h2; tail_o = 4'h2; cyc_o = 8'h04; rd_o = 2'h1; // RULE20
         end
         EA_DISP, EA_ABSW: begin
            head_o = 4'h1; tail_o = 4'h3; cyc_o = 8'h05; rd_o = 2'h1;
         end
         EA_IMMW: begin
            head_o = 4'h1; tail_o = 4'h1; cyc_o = 8'h03; rd_o = 2'h0;
         end
      endcase
      // Long operand takes a second bus cycle
      if (long_i && rd_o != 2'h0) begin
         rd_o   = 2'h2; // RULE14
         tail_o = tail_o + LONG_EXTRA; // RULE14
         cyc_o  = cyc_o + LONG_EXTRA_CYC;
      end
   end

endmodule
`default_nettype wire

// ### hdl/prefetch_overlap_timing.sv
// Behaviour
// RULE1: Two-word instruction pipe; start needs two words, up to three held.
// RULE2: A branch lasts at least three bus cycles.
// RULE3: After change of flow, third word fetched only on a fast bus.
// RULE4: Branch prefetches only what it needs; destination starts early.
// RULE5: Late branch displacement adds one clock.
// RULE6: Free bus and fewer than three words issues a prefetch at once.
// RULE7: Replacement prefetch may start before its instruction executes.
// RULE8: Bus runs beside address calculation; overlap is min of tail and head.
// RULE9: Reference timing: 16-bit bus, two-clock cycles, no waits, full pipe.
// RULE10: Each instruction exposes a head for prior writes or prefetches.
// RULE11: Each instruction exposes a tail of trailing write cycles.
// RULE12: Report total cycles plus reads, fetches and writes per instruction.
// RULE13: Four-clock long write tail hides under a four-clock head.
// RULE14: Variable operand count is one, two for long; long adds two tail.
// RULE15: Word extension must sit one cycle in the pipe before start.
// RULE16: After a negative tail, prefetch may begin during prior instruction.
// RULE17: Address-tail read does not overlap a zero-head operation.
// RULE18: Prefetch displaced by a trailing write is deferred, not dropped.
// RULE19: Slow memory stretches accesses; core stretches timing alike.
// RULE20: Operand fetch costs per mode: direct 0, indirect 3, predecrement 4.
// RULE21: Overlap of neighbours is min of earlier tail and later head.
// RULE22: Idle bus lets replacement prefetch start two clocks before the end.
// RULE23: Pending trailing write wins the bus over a queued prefetch.
`default_nettype none
module prefetch_overlap_timing
   import pot_pkg::*;
(
   input  wire logic       CORE_CLK_I,
   input  wire logic       SRST_I,
   input  wire logic       START_REQ_I,
   input  wire logic [3:0] OP_HEAD_I,
   input  wire logic [3:0] OP_TAIL_I,
   input  wire logic [7:0] OP_CYCLES_I,
   input  wire logic [2:0] EA_MODE_I,
   input  wire logic       LONG_I,
   input  wire logic       WRITE_I,
   input  wire logic       COF_I,
   input  wire logic       EXT_WORD_I,
   input  wire logic       DISP_LATE_I,
   input  wire logic [1:0] INSN_WORDS_I,
   input  wire logic       BUS_ACK_I,
   output logic            START_ACK_O,
   output logic            BUS_REQ_O,
   output logic            BUS_START_O,
   output logic      [1:0] BUS_KIND_O,
   output logic      [1:0] WORDS_O,
   output logic            EXEC_O,
   output logic            DONE_O,
   output logic      [3:0] HEAD_O,
   output logic      [3:0] TAIL_O,
   output logic      [7:0] CYCLES_O,
   output logic      [3:0] READS_O,
   output logic      [3:0] FETCHES_O,
   output logic      [3:0] WRITES_O
);

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_EXEC = 1'b1
   } st_e;

   typedef struct packed {
      st_e        st;
      logic [1:0] words;
      logic       fresh;
      logic       fast;
      logic       drop;
      logic       cof_lim;
      logic       cur_cof;
      logic       bus_act;
      logic       bus_start;
      bus_kind_e  bus_kind;
      logic [3:0] bus_cnt;
      logic [7:0] exec_left;
      logic [3:0] tail_left;
      logic [1:0] reads_owed;
      logic [1:0] writes_owed;
      logic [1:0] wr_next;
      logic [3:0] tail_next;
      logic       ack;
      logic       done;
      logic [3:0] head;
      logic [3:0] tail;
      logic [7:0] cyc;
      logic [3:0] rd;
      logic [3:0] pf;
      logic [3:0] wr;
      logic [7:0] cyc_cnt;
      logic [3:0] rd_cnt;
      logic [3:0] pf_cnt;
   } state_s;

   state_s     s;
   state_s     n;

   logic [3:0] ea_head;
   logic [3:0] ea_tail;
   logic [7:0] ea_cyc;
   logic [1:0] ea_rd;
   logic [3:0] ins_head;
   logic [3:0] ov_ea;
   logic [3:0] ov_prev;
   logic [7:0] base;
   logic [7:0] total;
   logic [1:0] used;
   logic [1:0] lim;
   logic       bus_end;
   logic       wait_st;
   logic       take;
   logic       finish;

   operand_fetch_address_timing u_ea (
      .mode_i (EA_MODE_I),
      .long_i (LONG_I),
      .head_o (ea_head),
      .tail_o (ea_tail),
      .cyc_o  (ea_cyc),
      .rd_o   (ea_rd)
   );

   // Length of the instruction being offered
   always_comb begin
      ins_head = (ea_cyc == 8'h00) ? OP_HEAD_I : ea_head; // RULE10
      // A zero-head operation serialises the operand read
      ov_ea    = (OP_HEAD_I == 4'h0) ? 4'h0 : min4(ea_tail, OP_HEAD_I); // RULE17 RULE8
      ov_prev  = min4(s.tail_left, ins_head); // RULE21 RULE13
      // Table figures never make the overlap exceed the cycle count
      base     = ea_cyc - {4'h0, ov_ea} + OP_CYCLES_I - {4'h0, ov_prev};
      if (COF_I && base < BRANCH_MIN_CYC) begin
         base = BRANCH_MIN_CYC; // RULE2
      end
      total = base + {7'h00, COF_I & DISP_LATE_I}; // RULE5
      if (total == 8'h00) begin
         total = 8'h01;
      end
      used = (s.words < INSN_WORDS_I) ? s.words : INSN_WORDS_I;
   end

   assign bus_end = s.bus_act && (s.bus_cnt >= BUS_LAST) && BUS_ACK_I; // RULE9
   assign wait_st = s.bus_act && (s.bus_cnt >= BUS_LAST) && !BUS_ACK_I;
   // Extension word must have aged one cycle in the pipe
   assign take    = (s.st == ST_IDLE) && START_REQ_I && (s.words >= MIN_WORDS)
                    && !(EXT_WORD_I && s.fresh); // RULE1 RULE15

   always_comb begin
      n           = s;
      n.ack       = 1'b0;
      n.done      = 1'b0;
      n.bus_start = 1'b0;
      n.fresh     = 1'b0;
      finish      = 1'b0;
      lim         = MAX_WORDS;

      if (s.bus_act && s.bus_cnt != 4'hF) begin
         n.bus_cnt = s.bus_cnt + 4'h1;
      end
      if (bus_end) begin
         n.bus_act = 1'b0;
         n.fast    = (s.bus_cnt == BUS_LAST); // RULE3 RULE19
         unique case (s.bus_kind)
            KIND_FETCH: begin
               if (!s.drop) begin
                  n.words = s.words + 2'h1;
                  n.fresh = 1'b1;
               end
               n.drop = 1'b0;
            end
            KIND_READ: begin
               n.reads_owed = s.reads_owed - 2'h1;
            end
            KIND_WRITE: begin
               n.writes_owed = s.writes_owed - 2'h1;
            end
            default: begin
            end
         endcase
      end

      if (s.tail_left != 4'h0) begin
         n.tail_left = s.tail_left - 4'h1;
      end

      if (s.st == ST_EXEC) begin
         n.cyc_cnt = s.cyc_cnt + 8'h01;
         // Wait states on an operand read stretch execution
         if (s.exec_left != 8'h00 && !(wait_st && s.bus_kind == KIND_READ)) begin
            n.exec_left = s.exec_left - 8'h01; // RULE19
         end
         finish = (s.exec_left == 8'h00) && (n.reads_owed == 2'h0) && (n.writes_owed == 2'h0)
                  && !(n.bus_act && s.bus_kind == KIND_READ);
         if (finish) begin
            n.st          = ST_IDLE;
            n.done        = 1'b1;
            n.cyc         = n.cyc_cnt; // RULE12
            n.rd          = s.rd_cnt;
            n.pf          = s.pf_cnt;
            n.wr          = {2'h0, s.wr_next};
            n.pf_cnt      = 4'h0;
            n.writes_owed = s.wr_next; // RULE11
            n.tail_left   = s.tail_next; // RULE11
            if (s.cur_cof) begin
               // Old stream is discarded, including a fetch still on the bus
               n.words   = 2'h0; // RULE4
               n.fresh   = 1'b0;
               n.cof_lim = 1'b1; // RULE3
               n.drop    = n.bus_act && (s.bus_kind == KIND_FETCH);
            end
         end
      end else if (take) begin
         n.st        = ST_EXEC;
         n.ack       = 1'b1;
         n.words     = n.words - used; // RULE1
         n.exec_left = total - 8'h01;
         n.head      = ins_head; // RULE10
         n.tail      = OP_TAIL_I + ((LONG_I && WRITE_I) ? LONG_EXTRA : 4'h0); // RULE14
         n.tail_next = n.tail;
         n.wr_next   = WRITE_I ? (LONG_I ? 2'h2 : 2'h1) : 2'h0; // RULE14
         n.reads_owed = ea_rd;
         n.cur_cof   = COF_I;
         n.cof_lim   = 1'b0;
         n.cyc_cnt   = 8'h00;
         n.rd_cnt    = 4'h0;
      end

      // Branch asks for no more than its own two words; slow bus skips the third
      if (n.st == ST_EXEC && n.cur_cof) begin
         lim = MIN_WORDS; // RULE4
      end else if (n.cof_lim && !n.fast) begin
         lim = MIN_WORDS; // RULE3
      end

      if (!n.bus_act) begin
         if (n.writes_owed != 2'h0) begin
            n.bus_act  = 1'b1; // RULE23
            n.bus_kind = KIND_WRITE;
         end else if (n.st == ST_EXEC && n.reads_owed != 2'h0) begin
            n.bus_act  = 1'b1;
            n.bus_kind = KIND_READ;
            n.rd_cnt   = n.rd_cnt + 4'h1;
         end else if (n.words < lim) begin
            // Deferred prefetch retries every idle slot, even mid-instruction
            n.bus_act  = 1'b1; // RULE6 RULE7 RULE16 RULE18 RULE22
            n.bus_kind = KIND_FETCH;
            n.pf_cnt   = n.pf_cnt + 4'h1;
         end
         if (n.bus_act) begin
            n.bus_start = 1'b1;
            n.bus_cnt   = 4'h0;
         end
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign START_ACK_O = s.ack;
   assign BUS_REQ_O   = s.bus_act;
   assign BUS_START_O = s.bus_start;
   assign BUS_KIND_O  = s.bus_kind;
   assign WORDS_O     = s.words;
   assign EXEC_O      = s.st;
   assign DONE_O      = s.done;
   assign HEAD_O      = s.head;
   assign TAIL_O      = s.tail;
   assign CYCLES_O    = s.cyc;
   assign READS_O     = s.rd;
   assign FETCHES_O   = s.pf;
   assign WRITES_O    = s.wr;

   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (SRST_I);

   sequence bus_hold;
      BUS_REQ_O [*2];
   endsequence

   sequence slow_read;
      EXEC_O && BUS_REQ_O && BUS_KIND_O == KIND_READ && s.bus_cnt >= BUS_LAST && !BUS_ACK_I
      && s.exec_left != 8'h00;
   endsequence

   start_two_words_a : assert property (START_ACK_O |-> $past(WORDS_O) >= MIN_WORDS) // RULE1
      else $error("instruction started with fewer than two words");
   words_cap_a : assert property (WORDS_O <= MAX_WORDS && !(DONE_O && s.cur_cof && WORDS_O != 2'h0)) // RULE4
      else $error("pipe over three words or not flushed on flow change");
   branch_min_a : assert property (DONE_O && s.cur_cof |-> CYCLES_O >= BRANCH_MIN_CYC) // RULE2
      else $error("branch shorter than three bus cycles");
   ext_age_a : assert property (START_ACK_O |-> !($past(EXT_WORD_I) && $past(s.fresh))) // RULE15
      else $error("extension word used in its arrival cycle");
   idle_fetch_a : assert property (!BUS_REQ_O && WORDS_O == 2'h0 |=> BUS_REQ_O && BUS_START_O) // RULE6
      else $error("empty pipe with idle bus left unfetched");
   write_first_a : assert property (BUS_START_O && BUS_KIND_O == KIND_FETCH |-> s.writes_owed == 2'h0) // RULE23
      else $error("prefetch taken ahead of pending write");
   bus_min_a : assert property (BUS_START_O |-> bus_hold) // RULE9
      else $error("bus access shorter than two clocks");
   read_stretch_a : assert property (slow_read |=> s.exec_left == $past(s.exec_left)) // RULE19
      else $error("execution ran on during read wait state");
   done_pulse_a : assert property (DONE_O |=> !DONE_O ##1 1'b1) // RULE12
      else $error("done lasted more than one cycle");
   tail_load_a : assert property (DONE_O |-> s.tail_left == TAIL_O && s.writes_owed == WRITES_O[1:0]) // RULE11
      else $error("tail or write count not loaded at instruction end");

endmodule
`default_nettype wire

// ### testbench/mem_model.sv
`default_nettype none
module mem_model
   import pot_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       req_i,
   input  wire logic [3:0] waits_i,
   output logic            ack_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt;
   // Ack only in the last cycle of an access; waits stretch it
   assign ack_o = req_i && (cnt == BUS_LAST + waits_i);
   always_ff @(posedge clk_i) begin
      if (rst_i || ack_o || !req_i) begin
         cnt <= 4'h0;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ### testbench/prefetch_overlap_timing_tb.sv
`default_nettype none
module prefetch_overlap_timing_tb
   import pot_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic       CORE_CLK_I = 1'b0, SRST_I = 1'b1, START_REQ_I = 1'b0, LONG_I = 1'b0;
   logic       WRITE_I = 1'b0, COF_I = 1'b0, EXT_WORD_I = 1'b0, DISP_LATE_I = 1'b0;
   logic [3:0] OP_HEAD_I = 4'h0, OP_TAIL_I = 4'h0, waits = 4'h0;
   logic [7:0] OP_CYCLES_I = 8'h00;
   logic [2:0] EA_MODE_I = 3'h0;
   logic [1:0] INSN_WORDS_I = 2'h1;
   logic       BUS_ACK_I, START_ACK_O, BUS_REQ_O, BUS_START_O, EXEC_O, DONE_O;
   logic [1:0] BUS_KIND_O, WORDS_O, maxw, prevw;
   logic [3:0] HEAD_O, TAIL_O, READS_O, FETCHES_O, WRITES_O, hd;
   logic [7:0] CYCLES_O;
   int         failures = 0, compares = 0, ticks = 0;

   prefetch_overlap_timing DUT (.CORE_CLK_I(CORE_CLK_I), .SRST_I(SRST_I), .START_REQ_I(START_REQ_I),
      .OP_HEAD_I(OP_HEAD_I), .OP_TAIL_I(OP_TAIL_I), .OP_CYCLES_I(OP_CYCLES_I), .EA_MODE_I(EA_MODE_I),
      .LONG_I(LONG_I), .WRITE_I(WRITE_I), .COF_I(COF_I), .EXT_WORD_I(EXT_WORD_I),
      .DISP_LATE_I(DISP_LATE_I), .INSN_WORDS_I(INSN_WORDS_I), .BUS_ACK_I(BUS_ACK_I),
      .START_ACK_O(START_ACK_O), .BUS_REQ_O(BUS_REQ_O), .BUS_START_O(BUS_START_O),
      .BUS_KIND_O(BUS_KIND_O), .WORDS_O(WORDS_O), .EXEC_O(EXEC_O), .DONE_O(DONE_O),
      .HEAD_O(HEAD_O), .TAIL_O(TAIL_O), .CYCLES_O(CYCLES_O), .READS_O(READS_O),
      .FETCHES_O(FETCHES_O), .WRITES_O(WRITES_O));
   mem_model mem (.clk_i(CORE_CLK_I), .rst_i(SRST_I), .req_i(BUS_REQ_O), .waits_i(waits),
      .ack_o(BUS_ACK_I));

   initial begin
      forever #25 CORE_CLK_I = ~CORE_CLK_I;
   end

   task automatic tally_and_finish();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Ceiling far above the few hundred cycles the tests need
   always @(posedge CORE_CLK_I) begin
      ticks++;
      if (ticks == 5000) begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Words held in the cycle before a start must already number two
   always @(negedge CORE_CLK_I) begin
      if (!SRST_I && START_ACK_O === 1'b1) chk({7'h0, prevw >= MIN_WORDS}, 8'h01);
      prevw = WORDS_O;
   end

   task automatic offer(input logic [2:0] m, input logic lg, wr, cf, ex, lt,
                        input logic [3:0] h, t, input logic [7:0] c);
      int n;
      @(posedge CORE_CLK_I);
      EA_MODE_I <= m;
      LONG_I <= lg;
      WRITE_I <= wr;
      COF_I <= cf;
      EXT_WORD_I <= ex;
      DISP_LATE_I <= lt;
      OP_HEAD_I <= h;
      OP_TAIL_I <= t;
      OP_CYCLES_I <= c;
      START_REQ_I <= 1'b1;
      n = 0;
      do begin
         @(negedge CORE_CLK_I);
         n++;
      end while (START_ACK_O !== 1'b1 && n < 200);
      // Limit ran out: never taken
      if (START_ACK_O !== 1'b1) failures++;
      hd = HEAD_O;
      maxw = WORDS_O;
      @(posedge CORE_CLK_I);
      START_REQ_I <= 1'b0;
   endtask

   task automatic wait_done();
      int n;
      n = 0;
      do begin
         @(negedge CORE_CLK_I);
         n++;
         if (EXEC_O === 1'b1 && WORDS_O > maxw) maxw = WORDS_O;
      end while (DONE_O !== 1'b1 && n < 300);
      // Limit ran out: never finished
      if (DONE_O !== 1'b1) failures++;
   endtask

   task automatic run(input logic [2:0] m, input logic lg, wr, cf, ex, lt,
                      input logic [3:0] h, t, input logic [7:0] c);
      offer(m, lg, wr, cf, ex, lt, h, t, c);
      wait_done();
   endtask

   task automatic test_reset();
      int n;
      repeat (2) @(negedge CORE_CLK_I);
      chk({5'h0, EXEC_O, BUS_REQ_O, DONE_O}, 8'h00);
      chk({6'h0, WORDS_O}, 8'h00);
      @(posedge CORE_CLK_I);
      SRST_I <= 1'b0;
      n = 0;
      do begin
         @(negedge CORE_CLK_I);
         n++;
      end while (WORDS_O < MIN_WORDS && n < 40);
      chk({7'h0, WORDS_O >= MIN_WORDS}, 8'h01);
      $display("test reset done");
   endtask

   task automatic test_modes();
      logic [7:0] cy [8] = '{8'h02, 8'h02, 8'h05, 8'h05, 8'h06, 8'h07, 8'h07, 8'h05};
      logic [3:0] he [8] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h1, 4'h1, 4'h1};
      logic [3:0] rd [8] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h0};
      for (int i = 0; i < 8; i++) begin
         // Word extension modes must still reach the same totals
         run(3'(i), 1'b0, 1'b0, 1'b0, i > 4, 1'b0, 4'h0, 4'h0, 8'h02);
         chk(CYCLES_O, cy[i]);
         chk({4'h0, hd}, {4'h0, he[i]});
         chk({4'h0, READS_O}, {4'h0, rd[i]});
      end
      run(EA_IND, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0, 8'h02);
      chk({4'h0, READS_O}, 8'h02);
      chk(CYCLES_O, 8'h07);
      run(EA_IND, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h2, 4'h0, 8'h02);
      chk(CYCLES_O, 8'h04);
      $display("test modes done");
   endtask

   task automatic test_overlap();
      offer(EA_DREG, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 4'h2, 8'h04);
      @(negedge CORE_CLK_I);
      chk({4'h0, TAIL_O}, 8'h04);
      // Second request waits through the first, so it is taken right at its end
      offer(EA_DREG, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h4, 4'h0, 8'h08);
      chk({4'h0, WRITES_O}, 8'h02);
      chk({4'h0, hd}, 8'h04);
      wait_done();
      chk(CYCLES_O, 8'h04);
      // Replacement fetch waits behind the two writes but still happens
      chk({4'h0, FETCHES_O}, 8'h01);
      $display("test overlap done");
   endtask

   task automatic test_branch();
      run(EA_DREG, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 4'h0, 8'h02);
      chk(CYCLES_O, BRANCH_MIN_CYC);
      chk({6'h0, maxw}, {6'h0, MIN_WORDS});
      run(EA_DREG, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 4'h0, 4'h0, 8'h02);
      chk(CYCLES_O, BRANCH_MIN_CYC + 8'h01);
      // Fast bus after a change of flow refills the third word
      repeat (8) @(negedge CORE_CLK_I);
      chk({6'h0, WORDS_O}, {6'h0, MAX_WORDS});
      $display("test branch done");
   endtask

   task automatic test_slow();
      waits = 4'h2;
      run(EA_DREG, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 4'h0, 8'h02);
      chk(CYCLES_O, BRANCH_MIN_CYC);
      // Slow bus after a change of flow leaves the third word unfetched
      repeat (16) @(negedge CORE_CLK_I);
      chk({6'h0, WORDS_O}, {6'h0, MIN_WORDS});
      run(EA_IND, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0, 8'h02);
      chk(CYCLES_O, 8'h07);
      waits = 4'h0;
      $display("test slow done");
   endtask

   initial begin
      test_reset();
      test_modes();
      test_overlap();
      test_branch();
      test_slow();
      tally_and_finish();
   end
endmodule
`default_nettype wire
